// file: core/bcs_pkg.sv
// Purpose: shared constants of the relay-bus controller command/status block
// Assumes: 32-bit apb data, one word per register
// Notes:   offsets are byte addresses
package bcs_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  OFS_STATUS    = 8'h00;
  localparam logic [7:0]  OFS_COMMAND   = 8'h04;
  localparam logic [7:0]  OFS_LAST_OP   = 8'h08;
  localparam logic [7:0]  OFS_EXCEPTION = 8'h0C;
  localparam logic [7:0]  OFS_NODE_STAT = 8'h10;
  // controller_status_reg bits
  localparam int          ST_RESET      = 0;
  localparam int          ST_INTERNAL   = 1;
  localparam int          ST_LINK       = 2;
  localparam int          ST_BUS        = 3;
  localparam int          ST_MISMATCH   = 4;
  localparam int          ST_LIMIT      = 5;
  localparam int          ST_TERM       = 6;
  localparam int          ST_BUSY       = 7;
  // node_status_reg bits
  localparam int          NS_RESET      = 0;
  localparam int          NS_INTERNAL   = 1;
  localparam int          NS_BUS        = 2;
  localparam int          NS_ALARM      = 3;
  // command_code_byte operation codes
  localparam logic [7:0]  OP_NONE       = 8'h00;
  localparam logic [7:0]  OP_SEQ_ROLL   = 8'h01;
  localparam logic [7:0]  OP_PRES_ROLL  = 8'h02;
  localparam logic [7:0]  OP_AUTOCONFIG = 8'h03;
  // exception codes
  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_FUNC      = 8'h01;
  localparam logic [7:0]  EXC_ADDR      = 8'h02;
  localparam logic [7:0]  EXC_DATA      = 8'h03;
  localparam logic [7:0]  EXC_ACK       = 8'h05;
  localparam logic [7:0]  EXC_BUSY      = 8'h06;
  typedef enum logic {
    BCS_IDLE,
    BCS_BUSY
  } bcs_state_e;
endpackage

// file: core/bcs_ctrl.sv
// Purpose: command interpreter and status registers of a relay-bus controller
// Assumes: inputs synchronous to clk (40 MHz), apb slave, operation engine outside
// Notes:   one wait state on every apb access; effects land on the pready edge
//
// Operation
// - controller reset flag records every reset event
// - reset flag set at power-up, cleared by reading status
// - internal error flag follows presence of any internal error
// - host link errors set a sticky link comm error flag
// - relay-node bus errors set a sticky bus error flag
// - mismatch and limit flags follow their error conditions
// - termination checked after power-up, fault sets termination flag
// - node status holds a node reset flag
// - node status holds internal and bus comm error flags
// - node status holds an alarm flag while alarm present
// - command written as opcode 1, 2 or 3 into command byte
// - accepted command answered with exception code 5, then busy
// - busy flag held while operation runs, cleared on completion
// - new commands refused while busy
// - while busy only status and last operation are readable
// - while busy node-directed requests dropped, no reply
//
// Implementation choices: the APB register port and the placing of the registers.
module bcs_ctrl #(
  parameter int ADDR_W = bcs_pkg::ADDR_W,
  parameter int DATA_W = bcs_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              op_done,
  input  wire logic              internal_error,
  input  wire logic              link_err,
  input  wire logic              node_bus_err,
  input  wire logic              mismatch_err,
  input  wire logic              limit_err,
  input  wire logic              term_fault,
  input  wire logic              node_int_err,
  input  wire logic              node_link_err,
  input  wire logic              node_alarm,
  input  wire logic              node_req,
  output logic                   controller_busy_flag,
  output logic                   op_start,
  output logic      [7:0]        op_code,
  output logic                   node_fwd
);

  bcs_pkg::bcs_state_e state_reg;
  logic                  ready_reg;
  logic                  slverr_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic [7:0]            resp_reg;
  logic [7:0]            resp_next;
  logic [DATA_W-1:0]     rdata_next;
  logic                  start_reg;
  logic [7:0]            opcode_reg;
  logic                  fwd_reg;
  logic [7:0]            last_op_reg;
  logic [7:0]            exception_reg;
  logic                  init_reg;
  logic                  controller_reset_flag;
  logic                  internal_error_flag;
  logic                  link_comm_error_flag;
  logic                  node_bus_error_flag;
  logic                  device_mismatch_flag;
  logic                  device_limit_flag;
  logic                  termination_error_flag;
  logic                  node_reset_flag;
  logic                  node_internal_flag;
  logic                  node_comm_flag;
  logic                  node_alarm_flag;
  logic                  busy;
  logic                  decide;
  logic                  acc;
  logic                  acc_ok;
  logic                  wr_status;
  logic                  wr_node;

  function automatic logic valid_op(input logic [7:0] code);
    valid_op = (code == bcs_pkg::OP_SEQ_ROLL) || (code == bcs_pkg::OP_PRES_ROLL) ||
               (code == bcs_pkg::OP_AUTOCONFIG);
  endfunction

  function automatic logic open_when_busy(input logic [ADDR_W-1:0] a, input logic wr);
    open_when_busy = !wr && (a == ADDR_W'(bcs_pkg::OFS_STATUS) || a == ADDR_W'(bcs_pkg::OFS_LAST_OP));
  endfunction

  assign busy      = (state_reg == bcs_pkg::BCS_BUSY);
  assign decide    = psel && penable && !ready_reg;
  assign acc       = psel && penable && ready_reg;
  assign acc_ok    = acc && (resp_reg == bcs_pkg::EXC_NONE);
  assign wr_status = acc_ok && pwrite && paddr == ADDR_W'(bcs_pkg::OFS_STATUS);
  assign wr_node   = acc_ok && pwrite && paddr == ADDR_W'(bcs_pkg::OFS_NODE_STAT);

  // access decision taken in the first access cycle, held until pready edge
  always_comb begin
    resp_next  = bcs_pkg::EXC_NONE;
    rdata_next = '0;
    if (busy && !open_when_busy(paddr, pwrite)) begin
      resp_next = bcs_pkg::EXC_BUSY;
    end else begin
      case (paddr)
        ADDR_W'(bcs_pkg::OFS_STATUS): begin
          rdata_next[bcs_pkg::ST_RESET]    = controller_reset_flag;
          rdata_next[bcs_pkg::ST_INTERNAL] = internal_error_flag;
          rdata_next[bcs_pkg::ST_LINK]     = link_comm_error_flag;
          rdata_next[bcs_pkg::ST_BUS]      = node_bus_error_flag;
          rdata_next[bcs_pkg::ST_MISMATCH] = device_mismatch_flag;
          rdata_next[bcs_pkg::ST_LIMIT]    = device_limit_flag;
          rdata_next[bcs_pkg::ST_TERM]     = termination_error_flag;
          rdata_next[bcs_pkg::ST_BUSY]     = busy;
        end
        ADDR_W'(bcs_pkg::OFS_COMMAND): begin
          if (pwrite) begin
            resp_next = valid_op(pwdata[7:0]) ? bcs_pkg::EXC_ACK : bcs_pkg::EXC_DATA;
          end
        end
        ADDR_W'(bcs_pkg::OFS_LAST_OP): begin
          if (pwrite) begin
            resp_next = bcs_pkg::EXC_FUNC;
          end
          rdata_next[7:0] = last_op_reg;
        end
        ADDR_W'(bcs_pkg::OFS_EXCEPTION): begin
          if (pwrite) begin
            resp_next = bcs_pkg::EXC_FUNC;
          end
          rdata_next[7:0] = exception_reg;
        end
        ADDR_W'(bcs_pkg::OFS_NODE_STAT): begin
          rdata_next[bcs_pkg::NS_RESET]    = node_reset_flag;
          rdata_next[bcs_pkg::NS_INTERNAL] = node_internal_flag;
          rdata_next[bcs_pkg::NS_BUS]      = node_comm_flag;
          rdata_next[bcs_pkg::NS_ALARM]    = node_alarm_flag;
        end
        default: begin
          resp_next = bcs_pkg::EXC_ADDR;
        end
      endcase
    end
  end

  // apb answer: one wait state, data and error registered with pready
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_reg  <= 1'b0;
      slverr_reg <= 1'b0;
      rdata_reg  <= '0;
      resp_reg   <= bcs_pkg::EXC_NONE;
    end else if (ce) begin
      ready_reg <= decide;
      if (decide) begin
        resp_reg   <= resp_next;
        slverr_reg <= resp_next != bcs_pkg::EXC_NONE && resp_next != bcs_pkg::EXC_ACK;
        rdata_reg  <= pwrite ? '0 : rdata_next;
      end else begin
        slverr_reg <= 1'b0;
        rdata_reg  <= '0;
      end
    end
  end

  // command state: accept, run, complete
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= bcs_pkg::BCS_IDLE;
      start_reg   <= 1'b0;
      opcode_reg  <= bcs_pkg::OP_NONE;
      last_op_reg <= bcs_pkg::OP_NONE;
    end else if (ce) begin
      start_reg <= 1'b0;
      case (state_reg)
        bcs_pkg::BCS_IDLE: begin
          if (acc && resp_reg == bcs_pkg::EXC_ACK) begin
            state_reg   <= bcs_pkg::BCS_BUSY;
            start_reg   <= 1'b1;
            opcode_reg  <= pwdata[7:0];
            last_op_reg <= pwdata[7:0];
          end
        end
        bcs_pkg::BCS_BUSY: begin
          if (op_done) begin
            state_reg <= bcs_pkg::BCS_IDLE;
          end
        end
        default: begin
          state_reg <= bcs_pkg::BCS_IDLE;
        end
      endcase
    end
  end

  // last answer code kept for software, including the acknowledge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exception_reg <= bcs_pkg::EXC_NONE;
    end else if (ce && acc) begin
      exception_reg <= resp_reg;
    end
  end

  // node-directed traffic is dropped while busy, not queued
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fwd_reg <= 1'b0;
    end else if (ce) begin
      fwd_reg <= node_req && !busy;
    end
  end

  // controller reset flag: read clears it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      controller_reset_flag <= 1'b1;
    end else if (ce && acc_ok && !pwrite && paddr == ADDR_W'(bcs_pkg::OFS_STATUS)) begin
      controller_reset_flag <= 1'b0;
    end
  end

  // level flags follow their causes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      internal_error_flag  <= 1'b0;
      device_mismatch_flag <= 1'b0;
      device_limit_flag    <= 1'b0;
    end else if (ce) begin
      internal_error_flag  <= internal_error;
      device_mismatch_flag <= mismatch_err;
      device_limit_flag    <= limit_err;
    end
  end

  // sticky error flags, write one to clear; a new error wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_comm_error_flag <= 1'b0;
      node_bus_error_flag  <= 1'b0;
    end else if (ce) begin
      link_comm_error_flag <= link_err ||
        (link_comm_error_flag && !(wr_status && pwdata[bcs_pkg::ST_LINK]));
      node_bus_error_flag  <= node_bus_err ||
        (node_bus_error_flag && !(wr_status && pwdata[bcs_pkg::ST_BUS]));
    end
  end

  // termination sampled once at the first enabled edge after reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_reg               <= 1'b0;
      termination_error_flag <= 1'b0;
    end else if (ce) begin
      init_reg <= 1'b1;
      if (!init_reg) begin
        termination_error_flag <= term_fault;
      end else if (wr_status && pwdata[bcs_pkg::ST_TERM]) begin
        termination_error_flag <= 1'b0;
      end
    end
  end

  // node status image
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      node_reset_flag    <= 1'b1;
      node_internal_flag <= 1'b0;
      node_comm_flag     <= 1'b0;
      node_alarm_flag    <= 1'b0;
    end else if (ce) begin
      if (acc_ok && !pwrite && paddr == ADDR_W'(bcs_pkg::OFS_NODE_STAT)) begin
        node_reset_flag <= 1'b0;
      end
      node_internal_flag <= node_int_err;
      node_comm_flag     <= node_link_err ||
        (node_comm_flag && !(wr_node && pwdata[bcs_pkg::NS_BUS]));
      node_alarm_flag    <= node_alarm;
    end
  end

  assign prdata               = rdata_reg;
  assign pready               = ready_reg;
  assign pslverr              = slverr_reg;
  assign controller_busy_flag = busy;
  assign op_start             = start_reg;
  assign op_code              = opcode_reg;
  assign node_fwd             = fwd_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  rst_flag_clear_a: assert property (
    ce && acc_ok && !pwrite && paddr == ADDR_W'(bcs_pkg::OFS_STATUS) |=> !controller_reset_flag)
    else $error("reset flag not cleared by status read");

  int_err_track_a: assert property (
    ce && decide && !pwrite && !busy && paddr == ADDR_W'(bcs_pkg::OFS_STATUS)
    |=> prdata[bcs_pkg::ST_INTERNAL] == $past(internal_error_flag))
    else $error("internal error bit misreported");

  link_err_set_a: assert property (
    ce && link_err |=> link_comm_error_flag)
    else $error("link error not flagged");

  bus_err_set_a: assert property (
    ce && node_bus_err |=> node_bus_error_flag)
    else $error("bus error not flagged");

  term_check_a: assert property (
    ce && !init_reg |=> termination_error_flag == $past(term_fault))
    else $error("termination fault not captured");

  cmd_accept_a: assert property (
    ce && acc && pwrite && !busy && paddr == ADDR_W'(bcs_pkg::OFS_COMMAND) && valid_op(pwdata[7:0])
    |=> controller_busy_flag && op_start && exception_reg == bcs_pkg::EXC_ACK && !pslverr)
    else $error("valid command not acknowledged");

  busy_hold_a: assert property (
    busy && !(ce && op_done) |=> busy)
    else $error("busy dropped before completion");

  busy_end_a: assert property (
    busy && ce && op_done |=> !busy)
    else $error("busy not cleared on completion");

  busy_reject_a: assert property (
    ce && decide && busy && pwrite |=> pslverr && pready ##1 !op_start)
    else $error("write accepted while busy");

  node_drop_a: assert property (
    ce && busy |=> !node_fwd)
    else $error("node request passed while busy");

  bad_op_a: assert property (
    ce && decide && !busy && pwrite && paddr == ADDR_W'(bcs_pkg::OFS_COMMAND) && !valid_op(pwdata[7:0])
    |=> pslverr ##1 !busy)
    else $error("undefined opcode not rejected");

  node_rst_a: assert property (
    $rose(nrst) |-> node_reset_flag)
    else $error("node reset flag not set after reset");

  cmd_run_c: cover property (op_start ##[1:20] (ce && op_done));
  busy_rej_c: cover property (busy && pslverr);
  node_fwd_c: cover property (node_fwd);
  st_poll_c: cover property (busy ##1 acc_ok && !pwrite);

endmodule // bcs_ctrl

// file: tb/bcs_host_model.sv
// Purpose: main controller model, apb master doing one transfer per request
// Assumes: request held high until the done pulse has been seen
// Notes:   address and data lines inverted once released, never left stale
module bcs_host_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  output logic             done,
  output logic      [31:0] rdata,
  output logic             err,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {psel, penable, pwrite, done, err} <= 5'h00;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      rdata <= 32'h0;
    end else begin
      done <= 1'b0;
      if (psel && penable) begin
        // request stands until pready is sampled high
        if (pready) begin
          {psel, penable} <= 2'h0;
          rdata <= prdata;
          err <= pslverr;
          done <= 1'b1;
          paddr <= ~paddr;
          pwdata <= ~pwdata;
        end
      end else if (psel) begin
        penable <= 1'b1;
      end else if (req && !done) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end
    end
  end
endmodule // bcs_host_model

// file: tb/tb.sv
// Purpose: self-checking bench for the command and status block
// Assumes: host model speaks apb, bench drives event and level inputs
// Notes:   table rows cover status flags, hand tests cover commands
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  drv;
    logic [7:0]  addr;
    logic [31:0] exp;
  } bcs_row_s;
  localparam logic [7:0] S = bcs_pkg::OFS_STATUS;
  localparam logic [7:0] N = bcs_pkg::OFS_NODE_STAT;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        op_done = 1'b0;
  logic        term_fault = 1'b1;
  logic        node_req = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  stim = 8'h00;
  logic        h_req = 1'b0;
  logic        h_wr = 1'b0;
  logic [7:0]  h_addr = 8'h00;
  logic [31:0] h_wdata = 32'h0;
  logic        h_done, h_err, psel, penable, pwrite, pready, pslverr, busy, op_start, node_fwd;
  logic [31:0] h_rdata, pwdata, prdata;
  logic [7:0]  paddr, op_code, op;
  int          err_total = 0;
  int          checked = 0;
  bcs_row_s    rows [8];
  always #12.5 clk = ~clk;
  bcs_host_model bcs_host_model_i (.clk(clk), .nrst(nrst), .req(h_req), .wr(h_wr), .addr(h_addr),
    .wdata(h_wdata), .done(h_done), .rdata(h_rdata), .err(h_err), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bcs_ctrl bcs_ctrl_i (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_done(op_done),
    .internal_error(stim[0]), .mismatch_err(stim[1]), .limit_err(stim[2]), .node_int_err(stim[3]),
    .node_alarm(stim[4]), .link_err(stim[5]), .node_bus_err(stim[6]), .node_link_err(stim[7]),
    .term_fault(term_fault), .node_req(node_req), .controller_busy_flag(busy), .op_start(op_start),
    .op_code(op_code), .node_fwd(node_fwd));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // read data only compared on accepted reads
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e,
                     input logic [31:0] x);
    @(posedge clk);
    h_wr <= w;
    h_addr <= a;
    h_wdata <= d;
    h_req <= 1'b1;
    // no local limit: only the watchdog ends a hung transfer
    do begin
      @(posedge clk);
    end while (h_done !== 1'b1);
    h_req <= 1'b0;
    chk({31'h0, h_err}, {31'h0, e});
    if (!w && !e) chk(h_rdata, x);
  endtask
  task automatic node_try(input logic exp);
    @(posedge clk);
    node_req <= 1'b1;
    @(posedge clk);
    node_req <= 1'b0;
    @(posedge clk);
    chk({31'h0, node_fwd}, {31'h0, exp});
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    rows = '{'{8'h01, S, 32'h02}, '{8'h02, S, 32'h10}, '{8'h04, S, 32'h20}, '{8'h20, S, 32'h04},
             '{8'h40, S, 32'h08}, '{8'h08, N, 32'h02}, '{8'h80, N, 32'h04}, '{8'h10, N, 32'h08}};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    acc(1'b0, S, 32'h0, 1'b0, 32'h41);
    term_fault <= 1'b0;
    acc(1'b0, S, 32'h0, 1'b0, 32'h40);
    acc(1'b0, N, 32'h0, 1'b0, 32'h01);
    acc(1'b0, N, 32'h0, 1'b0, 32'h00);
    acc(1'b1, S, 32'h40, 1'b0, 32'h0);
    acc(1'b0, S, 32'h0, 1'b0, 32'h00);
    foreach (rows[i]) begin
      stim <= rows[i].drv;
      @(posedge clk);
      stim[7:5] <= 3'h0;
      acc(1'b0, rows[i].addr, 32'h0, 1'b0, rows[i].exp);
      stim <= 8'h00;
      acc(1'b1, S, 32'h4C, 1'b0, 32'h0);
      acc(1'b1, N, 32'h04, 1'b0, 32'h0);
    end
    node_try(1'b1);
    foreach (rows[i]) begin
      op = (i == 0) ? 8'h00 : (i == 1) ? 8'h04 : 8'hFF;
      if (i < 3) begin
        acc(1'b1, bcs_pkg::OFS_COMMAND, {24'h0, op}, 1'b1, 32'h0);
        chk({31'h0, busy}, 32'h0);
      end
    end
    acc(1'b0, 8'h14, 32'h0, 1'b1, 32'h0);
    acc(1'b0, bcs_pkg::OFS_EXCEPTION, 32'h0, 1'b0, 32'h02);
    acc(1'b1, bcs_pkg::OFS_LAST_OP, 32'h1, 1'b1, 32'h0);
    for (op = 8'h01; op <= 8'h03; op++) begin
      acc(1'b0, S, 32'h0, 1'b0, 32'h00);
      acc(1'b1, bcs_pkg::OFS_COMMAND, {24'h0, op}, 1'b0, 32'h0);
      chk({30'h0, busy, op_start}, 32'h3);
      chk({24'h0, op_code}, {24'h0, op});
      acc(1'b0, S, 32'h0, 1'b0, 32'h80);
      acc(1'b0, bcs_pkg::OFS_LAST_OP, 32'h0, 1'b0, {24'h0, op});
      acc(1'b0, N, 32'h0, 1'b1, 32'h0);
      acc(1'b1, S, 32'h4C, 1'b1, 32'h0);
      acc(1'b1, bcs_pkg::OFS_COMMAND, {24'h0, op % 8'h03 + 8'h01}, 1'b1, 32'h0);
      chk({31'h0, op_start}, 32'h0);
      chk({24'h0, op_code}, {24'h0, op});
      node_try(1'b0);
      // completion seen while the clock enable is low must not end the operation
      @(posedge clk);
      ce <= 1'b0;
      op_done <= 1'b1;
      @(posedge clk);
      ce <= 1'b1;
      op_done <= 1'b0;
      @(posedge clk);
      chk({31'h0, busy}, 32'h1);
      @(posedge clk);
      op_done <= 1'b1;
      @(posedge clk);
      op_done <= 1'b0;
      acc(1'b0, S, 32'h0, 1'b0, 32'h00);
    end
    // second reset in mid-run must mark itself again
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    acc(1'b0, S, 32'h0, 1'b0, 32'h01);
    acc(1'b0, N, 32'h0, 1'b0, 32'h01);
    give_verdict();
  end
endmodule // tb
